/* src/sled_cfg.svh */
`ifndef SLED_CFG_SVH
`define SLED_CFG_SVH

// system clock rate and millisecond tick
`define SLED_CLK_HZ 200000000
`define SLED_TICK_MS 1
`define SLED_CYC_PER_MS ((`SLED_CLK_HZ / 1000) * `SLED_TICK_MS)

// pattern phase lengths in milliseconds
`define SLED_SLOW_MS 500
`define SLED_FAST_MS 125
`define SLED_FMT_MS 500

// pulses of each colour in the crash sequence
`define SLED_CRASH_PULSES 3

// state select encoding
`define SLED_SEL_RUN 3'h0
`define SLED_SEL_FORMAT 3'h1
`define SLED_SEL_ERROR 3'h2
`define SLED_SEL_CRASH 3'h3
`define SLED_SEL_UPD_IDLE 3'h4
`define SLED_SEL_UPD_INST 3'h5
`define SLED_SEL_RESET 3'h6
`define SLED_SEL_OFF 3'h7

`endif

/* src/sled_pkg.sv */
`default_nettype none
package sled_pkg;

  typedef logic [2:0] sled_sel_type;

  typedef enum logic [3:0] {
    SLED_PH_ON = 4'h1,
    SLED_PH_OFF = 4'h2,
    SLED_PH_ALT_A = 4'h4,
    SLED_PH_ALT_B = 4'h8
  } sled_phase_type;

endpackage

`default_nettype wire

/* src/sled_driver.sv */
// Contract
// - while the firmware runs normally the health LED is steady green.
// - during file system formatting the health LED blinks green in phases.
// - with a system error present the health LED is steady yellow.
// - on a crash it repeats 3 yellow then 3 green pulses, 500 ms on/off.
// - update idle alternates yellow 500 ms and green 500 ms.
// - update install alternates yellow 125 ms and green 125 ms.
// - both colours stay dark while a firmware reset is in progress.
// - communication and Ethernet LEDs are driven by firmware, registered here.
`timescale 1ns/100ps
`default_nettype none
`include "sled_cfg.svh"

module sled_driver (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // firmware state
  input wire sled_pkg::sled_sel_type state_sel,
  // communication and ethernet patterns from firmware
  input wire logic [1:0] com0_fw,
  input wire logic [1:0] com1_fw,
  input wire logic [3:0] eth_fw,
  // leds
  output logic health_indicator_led_green,
  output logic health_indicator_led_yellow,
  output logic [1:0] com0_led,
  output logic [1:0] com1_led,
  output logic [3:0] eth_led
);
  import sled_pkg::*;

  localparam int unsigned TICK_CYC = `SLED_CYC_PER_MS;
  localparam logic [17:0] TICK_LAST = 18'(TICK_CYC - 1);
  localparam logic [9:0] SLOW_LAST = 10'(`SLED_SLOW_MS - 1);
  localparam logic [9:0] FAST_LAST = 10'(`SLED_FAST_MS - 1);
  localparam logic [9:0] FMT_LAST = 10'(`SLED_FMT_MS - 1);
  localparam logic [2:0] PULSE_LAST = 3'(`SLED_CRASH_PULSES - 1);

  // ms tick divider
  logic [17:0] div_q, div_d;
  logic tick;

  // pattern state
  sled_sel_type sel_q, sel_d;
  sled_phase_type ph_q, ph_d;
  logic [9:0] ms_q, ms_d;
  logic [2:0] pulse_q, pulse_d;
  logic crash_green_q, crash_green_d;
  logic grn_q, grn_d, yel_q, yel_d;

  // firmware driven pass-through leds
  logic [1:0] com0_q, com0_d;
  logic [1:0] com1_q, com1_d;
  logic [3:0] eth_q, eth_d;

  function automatic logic [9:0] phase_last(input sled_sel_type s);
    if (s == `SLED_SEL_UPD_INST) begin
      phase_last = FAST_LAST;
    end else if (s == `SLED_SEL_FORMAT) begin
      phase_last = FMT_LAST;
    end else begin
      phase_last = SLOW_LAST;
    end
  endfunction

  // first phase after a state change
  function automatic sled_phase_type first_phase(input sled_sel_type s);
    if (s == `SLED_SEL_CRASH || s == `SLED_SEL_FORMAT) begin
      first_phase = SLED_PH_ON;
    end else begin
      first_phase = SLED_PH_ALT_A;
    end
  endfunction

  function automatic logic phase_on(input sled_phase_type p);
    phase_on = (p == SLED_PH_ON);
  endfunction

  always_comb begin
    tick = (div_q == TICK_LAST);
    div_d = tick ? 18'h00000 : div_q + 18'h00001;
  end

  always_comb begin
    sel_d = state_sel;
    ph_d = ph_q;
    ms_d = ms_q;
    pulse_d = pulse_q;
    crash_green_d = crash_green_q;
    if (state_sel != sel_q) begin
      // restart from first phase
      ph_d = first_phase(state_sel);
      ms_d = 10'h000;
      pulse_d = 3'h0;
      crash_green_d = 1'b0;
    end else if (tick) begin
      if (ms_q == phase_last(sel_q)) begin
        ms_d = 10'h000;
        case (ph_q)
          SLED_PH_ON: begin
            ph_d = SLED_PH_OFF;
          end
          SLED_PH_OFF: begin
            ph_d = SLED_PH_ON;
            if (sel_q == `SLED_SEL_CRASH) begin
              if (pulse_q == PULSE_LAST) begin
                pulse_d = 3'h0;
                crash_green_d = ~crash_green_q;
              end else begin
                pulse_d = pulse_q + 3'h1;
              end
            end
          end
          SLED_PH_ALT_A: begin
            ph_d = SLED_PH_ALT_B;
          end
          SLED_PH_ALT_B: begin
            ph_d = SLED_PH_ALT_A;
          end
          default: begin
            ph_d = SLED_PH_ALT_A;
          end
        endcase
      end else begin
        ms_d = ms_q + 10'h001;
      end
    end
  end

  always_comb begin
    grn_d = 1'b0;
    yel_d = 1'b0;
    case (sel_q)
      `SLED_SEL_RUN: begin
        grn_d = 1'b1;
      end
      `SLED_SEL_FORMAT: begin
        grn_d = phase_on(ph_q);
      end
      `SLED_SEL_ERROR: begin
        yel_d = 1'b1;
      end
      `SLED_SEL_CRASH: begin
        grn_d = phase_on(ph_q) && crash_green_q;
        yel_d = phase_on(ph_q) && !crash_green_q;
      end
      `SLED_SEL_UPD_IDLE, `SLED_SEL_UPD_INST: begin
        yel_d = (ph_q == SLED_PH_ALT_A);
        grn_d = (ph_q == SLED_PH_ALT_B);
      end
      `SLED_SEL_RESET: begin
        grn_d = 1'b0;
        yel_d = 1'b0;
      end
      default: begin
        grn_d = 1'b0;
        yel_d = 1'b0;
      end
    endcase
  end

  always_comb begin
    com0_d = com0_fw;
    com1_d = com1_fw;
    eth_d = eth_fw;
  end

  // divider register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 18'h00000;
    end else begin
      div_q <= div_d;
    end
  end

  // pattern registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= `SLED_SEL_RESET;
      ph_q <= SLED_PH_ALT_A;
      ms_q <= 10'h000;
      pulse_q <= 3'h0;
      crash_green_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      ph_q <= ph_d;
      ms_q <= ms_d;
      pulse_q <= pulse_d;
      crash_green_q <= crash_green_d;
    end
  end

  // health led registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      grn_q <= 1'b0;
      yel_q <= 1'b0;
    end else begin
      grn_q <= grn_d;
      yel_q <= yel_d;
    end
  end

  // pass-through registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      com0_q <= 2'h0;
      com1_q <= 2'h0;
      eth_q <= 4'h0;
    end else begin
      com0_q <= com0_d;
      com1_q <= com1_d;
      eth_q <= eth_d;
    end
  end

  assign health_indicator_led_green = grn_q;
  assign health_indicator_led_yellow = yel_q;
  assign com0_led = com0_q;
  assign com1_led = com1_q;
  assign eth_led = eth_q;

endmodule

`default_nettype wire

/* verification/sled_props.sv */
`timescale 1ns/100ps
`default_nettype none
module sled_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // watched ports
  input wire sled_pkg::sled_sel_type state_sel,
  input wire logic [1:0] com0_fw,
  input wire logic [1:0] com1_fw,
  input wire logic [3:0] eth_fw,
  input wire logic [1:0] com0_led,
  input wire logic [1:0] com1_led,
  input wire logic [3:0] eth_led,
  input wire logic health_indicator_led_green,
  input wire logic health_indicator_led_yellow
);
  import sled_pkg::*;
  wire logic g = health_indicator_led_green;
  wire logic y = health_indicator_led_yellow;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property hold_p(c, gv, yv);
    (state_sel == c) [*4] |-> g == gv && y == yv;
  endproperty
  property start_p(c, gv, yv);
    state_sel != c ##1 (state_sel == c) [*3] |-> g == gv && y == yv;
  endproperty
  run_green_a: assert property (hold_p(3'h0, 1'b1, 1'b0))
    else $error("bad run led");
  error_yellow_a: assert property (hold_p(3'h2, 1'b0, 1'b1))
    else $error("bad error led");
  reset_dark_a: assert property (hold_p(3'h6, 1'b0, 1'b0))
    else $error("reset led lit");
  format_start_a: assert property (start_p(3'h1, 1'b1, 1'b0))
    else $error("bad format start");
  crash_start_a: assert property (start_p(3'h3, 1'b0, 1'b1))
    else $error("bad crash start");
  idle_start_a: assert property (start_p(3'h4, 1'b0, 1'b1))
    else $error("bad idle start");
  install_start_a: assert property (start_p(3'h5, 1'b0, 1'b1))
    else $error("bad install start");
  eth_copy_a: assert property (
    !$past(sys_rst) |-> eth_led == $past(eth_fw)) else $error("bad eth");
  com_copy_a: assert property (
    !$past(sys_rst) |-> com0_led == $past(com0_fw) &&
    com1_led == $past(com1_fw)) else $error("bad com");
  off_dark_a: assert property (hold_p(3'h7, 1'b0, 1'b0))
    else $error("off led lit");
  colour_excl_a: assert property (!(g && y))
    else $error("both colours lit");
  format_c: cover property ((state_sel == 3'h1) [*8]);
  crash_c: cover property ((state_sel == 3'h3) [*8]);
  idle_c: cover property ((state_sel == 3'h4) [*8]);
  install_c: cover property ((state_sel == 3'h5) [*8]);
endmodule
`default_nettype wire

/* verification/sled_led_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sled_led_model (
  input wire logic clk_sys,
  input wire logic green,
  input wire logic yellow,
  output logic [1:0] colour,
  output logic chg
);
  // colour is {yellow, green}; chg marks a new colour
  always @(posedge clk_sys) begin
    colour <= {yellow, green};
    chg <= {yellow, green} != colour;
  end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sled_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  sled_sel_type state_sel = 3'h6;
  logic [7:0] fw = 8'h00;
  logic [31:0] rnd = 32'h3067;
  logic g, y, chg;
  logic [1:0] colour;
  logic [1:0] exp_q[$];
  int mismatches = 0;
  int compares = 0;
  int sel_t[10] = '{0, 2, 1, 6, 4, 7, 5, 0, 3, 6};
  int col_t[10] = '{1, 2, 1, 0, 2, 0, 2, 1, 2, 0};
  sled_driver sled_driver_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .state_sel(state_sel), .com0_fw(fw[1:0]), .com1_fw(fw[3:2]),
    .eth_fw(fw[7:4]), .health_indicator_led_green(g),
    .health_indicator_led_yellow(y), .com0_led(), .com1_led(),
    .eth_led());
  sled_led_model sled_led_model_inst (.clk_sys(clk_sys), .green(g),
    .yellow(y), .colour(colour), .chg(chg));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [1:0] seen, input logic [1:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch t=%0t led %b want %b", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rnd <= xs(rnd);
    fw <= rnd[7:0];
    if (!sys_rst && chg !== 1'b0) begin
      if (exp_q.size() == 0) check(colour, ~colour);
      else check(colour, exp_q.pop_front());
    end
  end
  initial begin
    int n;
    logic hung;
    hung = 1'b0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10 && !hung; i++) begin
      @(posedge clk_sys);
      state_sel <= sel_t[i][2:0];
      exp_q.push_back(col_t[i][1:0]);
      n = 0;
      while (exp_q.size() != 0 && n < 40) begin
        @(posedge clk_sys);
        n++;
      end
      if (exp_q.size() != 0) begin
        mismatches++;
        hung = 1'b1;
      end else begin
        // window in which no further colour change may appear
        repeat (20) @(posedge clk_sys);
      end
    end
    finish_test();
  end
endmodule
bind sled_driver sled_props sled_props_inst (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .state_sel(state_sel), .com0_fw(com0_fw),
  .com1_fw(com1_fw), .eth_fw(eth_fw), .com0_led(com0_led),
  .com1_led(com1_led), .eth_led(eth_led),
  .health_indicator_led_green(health_indicator_led_green),
  .health_indicator_led_yellow(health_indicator_led_yellow));
`default_nettype wire
